/* logic/dma_request_lock_swap_regs.sv */
module dma_request_lock_swap_regs #(
    // Arbitrary revision value
    parameter logic [15:0] REVISION = 16'h0100
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Host memory bus
    input  wire logic [15:0]         hostAddr,
    input  wire logic [15:0]         hostDataIn,
    input  wire logic                ceN,
    input  wire logic                oeN,
    input  wire logic                weN,
    output logic      [15:0]         hostDataOut,
    output logic                     hostDataOe,
    // Boot block loading from flash
    input  wire logic                bootLoadValid,
    input  wire logic [9:0]          bootLoadAddr,
    input  wire logic [15:0]         bootLoadData,
    // Transfer engine
    input  wire logic                xferStart,
    input  wire logic [15:0]         xferWords,
    output logic                     transferRequestOut,
    // Protected partitions
    input  wire logic                protAccessReq,
    output logic                     protAccessGrant,
    // Status
    output logic                     stickyPartitionLock,
    output logic                     byteSwapOn,
    output logic                     bootMode
);
    import flash_ctl_pkg::*;

    typedef struct packed {
        logic        dmaEn;
        logic        requestPolarity;
        logic        edgeMode;
        logic [4:0]  pulseWidth;
        logic [9:0]  earlyNegationCount;
        logic        lock;
        logic        swap;
        logic        bootMode;
        logic        readSeen;
        logic        writeSeen;
        logic [15:0] lastAddr;
        logic [15:0] readData;
        logic        dataOe;
        logic        protGrant;
    } regs_t;

    regs_t s;
    regs_t next_s;

    logic [15:0] bootMem [BOOT_DEPTH];

    // ==========================================================
    // Bus decode
    logic        hostRead;
    logic        hostWrite;
    logic        readStart;
    logic        writeStrobe;
    logic        isBoot;
    logic        regWrite;
    logic        readUpdate;
    logic [15:0] bootWord;
    logic [15:0] bootRdSw;
    logic [15:0] wrSw;
    logic [15:0] regValue;

    function automatic logic [15:0] swapBytes(input logic [15:0] w,
                                              input logic en);
        swapBytes = en ? {w[7:0], w[15:8]} : w;
    endfunction

    assign hostRead    = !ceN && !oeN;
    assign hostWrite   = !ceN && !weN;
    assign readStart   = hostRead && !s.readSeen;
    assign writeStrobe = hostWrite && !s.writeSeen;
    assign isBoot      = hostAddr < BOOT_LIMIT;
    // Odd address locks out the register space
    assign regWrite    = writeStrobe && !isBoot && !hostAddr[0];
    // Boot mode follows address changes in a held burst
    assign readUpdate  = readStart ||
                         (hostRead && s.bootMode &&
                          hostAddr != s.lastAddr);
    assign bootWord    = bootMem[hostAddr[BOOT_AW:1]];
    assign bootRdSw    = swapBytes(bootWord, s.swap);
    assign wrSw        = swapBytes(hostDataIn, s.swap);

    // ==========================================================
    // Register readback, reserved bits zero
    always_comb begin
        regValue = 16'h0000;
        unique case (hostAddr)
            DMA_CTRL_OFS: begin
                regValue[EN_BIT]        = s.dmaEn;
                regValue[POL_BIT]       = s.requestPolarity;
                regValue[EDGE_BIT]      = s.edgeMode;
                regValue[PW_MSB:PW_LSB] = s.pulseWidth;
            end
            LOCK_OFS: regValue[LOCK_BIT] = s.lock;
            ORDER_OFS: begin
                regValue[SWAP_LO_BIT] = s.swap;
                regValue[SWAP_HI_BIT] = s.swap;
            end
            NEG_OFS:  regValue[NEG_MSB:0] = s.earlyNegationCount;
            REV_OFS:  regValue = REVISION;
            default:  regValue = 16'h0000;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_s           = s;
        next_s.readSeen  = hostRead;
        next_s.writeSeen = hostWrite;
        next_s.protGrant = protAccessReq && !s.lock;

        if (regWrite) begin
            unique case (hostAddr)
                DMA_CTRL_OFS: begin
                    next_s.dmaEn           = hostDataIn[EN_BIT];
                    next_s.requestPolarity = hostDataIn[POL_BIT];
                    next_s.edgeMode        = hostDataIn[EDGE_BIT];
                    next_s.pulseWidth      = hostDataIn[PW_MSB:PW_LSB];
                end
                LOCK_OFS: begin
                    // Writes can only set, never clear
                    next_s.lock = s.lock | hostDataIn[LOCK_BIT];
                end
                ORDER_OFS: begin
                    // Either copy sets, both zero clears
                    next_s.swap = hostDataIn[SWAP_LO_BIT] |
                                  hostDataIn[SWAP_HI_BIT];
                end
                NEG_OFS: begin
                    next_s.earlyNegationCount = hostDataIn[NEG_MSB:0];
                end
                default: begin
                end
            endcase
            // First register write ends the boot phase
            next_s.bootMode = 1'b0;
        end

        if (!hostRead) begin
            next_s.dataOe = 1'b0;
        end else if (readUpdate) begin
            next_s.lastAddr = hostAddr;
            if (isBoot) begin
                // Fetches served from the boot block
                next_s.readData = bootRdSw;
                next_s.dataOe   = 1'b1;
            end else if (hostAddr[0]) begin
                // Bus left undriven on a refused read
                next_s.readData = 16'h0000;
                next_s.dataOe   = 1'b0;
            end else begin
                next_s.readData = regValue;
                next_s.dataOe   = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s.dmaEn              <= EN_RST;
            s.requestPolarity    <= POL_RST;
            s.edgeMode           <= EDGE_RST;
            s.pulseWidth         <= PW_RST;
            s.earlyNegationCount <= NEG_RST;
            s.lock               <= LOCK_RST;
            s.swap               <= SWAP_RST;
            s.bootMode           <= 1'b1;
            s.readSeen           <= 1'b0;
            s.writeSeen          <= 1'b0;
            s.lastAddr           <= 16'h0000;
            s.readData           <= 16'h0000;
            s.dataOe             <= 1'b0;
            s.protGrant          <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // Boot block: flash loads win over host writes in the same cycle
    always_ff @(posedge core_clk) begin
        if (bootLoadValid) begin
            bootMem[bootLoadAddr] <= bootLoadData;
        end else if (writeStrobe && isBoot) begin
            bootMem[hostAddr[BOOT_AW:1]] <= wrSw;
        end
    end

    // ==========================================================
    // Request generator
    dma_request_gen u_req (
        .core_clk   (core_clk),
        .rst        (rst),
        .enable     (s.dmaEn),
        .polarity   (s.requestPolarity),
        .edgeMode   (s.edgeMode),
        .pulseWidth (s.pulseWidth),
        .negCount   (s.earlyNegationCount),
        .xferStart  (xferStart),
        .xferWords  (xferWords),
        .reqOut     (transferRequestOut)
    );

    assign hostDataOut         = s.readData;
    assign hostDataOe          = s.dataOe;
    assign protAccessGrant     = s.protGrant;
    assign stickyPartitionLock = s.lock;
    assign byteSwapOn          = s.swap;
    assign bootMode            = s.bootMode;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    lock_sticky_a: assert property (
        s.lock |=> s.lock [*4])
        else $error("sticky lock cleared without reset");

    lock_blocks_a: assert property (
        s.lock && protAccessReq |=> !protAccessGrant)
        else $error("protected access granted while locked");

    odd_refused_a: assert property (
        writeStrobe && !isBoot && hostAddr[0] |=>
        $stable({s.dmaEn, s.requestPolarity, s.edgeMode, s.pulseWidth,
                 s.earlyNegationCount, s.lock, s.swap}))
        else $error("register changed on odd address write");

    swap_set_a: assert property (
        regWrite && hostAddr == ORDER_OFS &&
        (hostDataIn[SWAP_LO_BIT] || hostDataIn[SWAP_HI_BIT])
        |=> byteSwapOn)
        else $error("swap not enabled by bit 0 or bit 8");

    swap_clear_a: assert property (
        regWrite && hostAddr == ORDER_OFS &&
        !hostDataIn[SWAP_LO_BIT] && !hostDataIn[SWAP_HI_BIT]
        |=> !byteSwapOn)
        else $error("swap not cleared by writing both bits zero");

    boot_fresh_a: assert property (
        s.bootMode && hostRead && $past(hostRead) && isBoot &&
        !bootLoadValid && !writeStrobe && hostAddr != s.lastAddr
        |=> hostDataOe && hostDataOut == $past(bootRdSw))
        else $error("boot burst did not return data for new address");

    revision_ro_a: assert property (
        readUpdate && hostAddr == REV_OFS |=> hostDataOut == REVISION)
        else $error("revision readback wrong");

    boot_exit_a: assert property (
        regWrite |=> !bootMode ##1 !bootMode)
        else $error("boot phase not left after register write");

    swap_read_a: assert property (
        readStart && isBoot && s.swap && !bootLoadValid && !writeStrobe
        |=> hostDataOut == {$past(bootWord[7:0]), $past(bootWord[15:8])})
        else $error("boot read not byte swapped");

endmodule

/* logic/flash_ctl_pkg.sv */
package flash_ctl_pkg;

    // ==========================================================
    // Register offsets (byte addresses on the host bus)
    localparam logic [15:0] DMA_CTRL_OFS  = 16'h940E;
    localparam logic [15:0] LOCK_OFS      = 16'h9410;
    localparam logic [15:0] ORDER_OFS     = 16'h9412;
    localparam logic [15:0] NEG_OFS       = 16'h9418;
    localparam logic [15:0] REV_OFS       = 16'h941A;

    // ==========================================================
    // Field positions
    localparam int EN_BIT      = 0;
    localparam int POL_BIT     = 1;
    localparam int EDGE_BIT    = 2;
    localparam int PW_LSB      = 4;
    localparam int PW_MSB      = 8;
    localparam int NEG_MSB     = 9;
    localparam int LOCK_BIT    = 0;
    localparam int SWAP_LO_BIT = 0;
    localparam int SWAP_HI_BIT = 8;

    // ==========================================================
    // Values after reset
    localparam logic       EN_RST   = 1'b0;
    localparam logic       POL_RST  = 1'b1;
    localparam logic       EDGE_RST = 1'b0;
    localparam logic [4:0] PW_RST   = 5'h4;
    localparam logic [9:0] NEG_RST  = 10'h004;
    localparam logic       LOCK_RST = 1'b0;
    localparam logic       SWAP_RST = 1'b0;

    // ==========================================================
    // Boot block geometry
    localparam logic [15:0] BOOT_LIMIT = 16'h0800;
    localparam int          BOOT_DEPTH = 1024;
    localparam int          BOOT_AW    = 10;

    typedef enum logic [1:0] {
        REQ_IDLE,
        REQ_LEVEL,
        REQ_PULSE
    } req_phase_t;

endpackage

/* logic/dma_request_gen.sv */
module dma_request_gen (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Settings
    input  wire logic        enable,
    input  wire logic        polarity,
    input  wire logic        edgeMode,
    input  wire logic [4:0]  pulseWidth,
    input  wire logic [9:0]  negCount,
    // Transfer events
    input  wire logic        xferStart,
    input  wire logic [15:0] xferWords,
    // Request pin
    output logic             reqOut
);
    import flash_ctl_pkg::*;

    typedef struct packed {
        req_phase_t  phase;
        logic [15:0] remain;
        logic        active;
        logic        pulseRun;
        logic [4:0]  width;
        logic        reqOut;
    } gen_t;

    gen_t s;
    gen_t next_s;

    always_comb begin
        next_s = s;
        unique case (s.phase)
            REQ_IDLE: begin
                next_s.active = 1'b0;
                if (xferStart && enable && pulseWidth != 5'h0) begin
                    if (edgeMode) begin
                        next_s.phase    = REQ_PULSE;
                        next_s.remain   = {11'h000, pulseWidth};
                        next_s.width    = pulseWidth;
                        next_s.active   = 1'b1;
                        next_s.pulseRun = 1'b1;
                    end else if (xferWords > {6'h00, negCount}) begin
                        // Transfer counted one word per clock
                        next_s.phase    = REQ_LEVEL;
                        next_s.remain   = xferWords;
                        next_s.active   = 1'b1;
                        next_s.pulseRun = 1'b0;
                    end
                end
            end
            REQ_LEVEL: begin
                next_s.remain = s.remain - 16'h0001;
                // Drop negCount clocks before the end
                next_s.active = (s.remain - 16'h0001) > {6'h00, negCount};
                if (!next_s.active) begin
                    next_s.phase = REQ_IDLE;
                end
            end
            REQ_PULSE: begin
                next_s.remain = s.remain - 16'h0001;
                next_s.active = s.remain > 16'h0001;
                if (!next_s.active) begin
                    next_s.phase = REQ_IDLE;
                end
            end
        endcase
        // A zero width or a disable ends any request at once
        if (!enable || pulseWidth == 5'h0) begin
            next_s.phase  = REQ_IDLE;
            next_s.active = 1'b0;
        end
        // Inactive level follows the polarity
        next_s.reqOut = enable ? (next_s.active ^ polarity) : polarity;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '{REQ_IDLE, 16'h0000, 1'b0, 1'b0, 5'h0, 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign reqOut = s.reqOut;

    // ==========================================================
    // Checks
    logic [5:0] runLen;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            runLen <= 6'h00;
        end else if (s.active) begin
            runLen <= runLen + 6'h01;
        end else begin
            runLen <= 6'h00;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    zero_width_a: assert property (
        pulseWidth == 5'h0 |=> reqOut == $past(polarity))
        else $error("request asserted with zero width");

    disabled_idle_a: assert property (
        !enable |=> reqOut == $past(polarity))
        else $error("request not inactive while disabled");

    pulse_len_a: assert property (
        $fell(s.active) && s.pulseRun && $past(enable) &&
        $past(pulseWidth) != 5'h0 |-> runLen == {1'b0, s.width})
        else $error("pulse length differs from programmed width");

    pin_tracks_a: assert property (
        enable && $past(enable) |-> reqOut == (s.active ^ $past(polarity)))
        else $error("request pin disagrees with request state");

    level_neg_a: assert property (
        s.phase == REQ_LEVEL && s.remain > {6'h00, negCount} &&
        s.remain <= {6'h00, negCount} + 16'h0001 && enable &&
        pulseWidth != 5'h0 |=> !s.active)
        else $error("level request not negated at programmed count");

endmodule

/* verif/host_bus_model.sv */
module host_bus_model (
    // Clock
    input  wire logic        core_clk,
    // Host memory bus
    output logic      [15:0] hostAddr,
    output logic      [15:0] hostDataIn,
    output logic             ceN,
    output logic             oeN,
    output logic             weN,
    input  wire logic [15:0] hostDataOut,
    input  wire logic        hostDataOe,
    // Request pin as the DMA controller sees it
    input  wire logic        transferRequestOut,
    input  wire logic        actLow,
    input  wire logic        watch,
    // Last result seen
    output logic      [15:0] seenValue
);
    timeunit 1ns;
    timeprecision 1ns;

    event        seen;
    logic [15:0] runLen;

    initial begin
        hostAddr   = 16'h0000;
        hostDataIn = 16'h0000;
        ceN        = 1'b1;
        oeN        = 1'b1;
        weN        = 1'b1;
        seenValue  = 16'h0000;
        runLen     = 16'h0000;
    end

    task automatic post(input logic [15:0] v);
        seenValue = v;
        -> seen;
    endtask

    // ==========================================================
    // Bus cycles; addresses are issued as given, odd ones included
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        hostAddr   <= a;
        hostDataIn <= d;
        ceN        <= 1'b0;
        weN        <= 1'b0;
        @(posedge core_clk);
        ceN        <= 1'b1;
        weN        <= 1'b1;
        // Released lines must not keep looking valid
        hostAddr   <= ~a;
        hostDataIn <= ~d;
    endtask

    // Held-strobe burst of incrementing addresses
    task automatic rd(input logic [15:0] a, input int n);
        @(posedge core_clk);
        ceN      <= 1'b0;
        oeN      <= 1'b0;
        hostAddr <= a;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            @(negedge core_clk);
            // Floating data bus reads as all ones here
            post(hostDataOe ? hostDataOut : 16'hFFFF);
            @(posedge core_clk);
            if (i + 1 < n)
                hostAddr <= a + 16'(2 * (i + 1));
        end
        ceN      <= 1'b1;
        oeN      <= 1'b1;
        hostAddr <= ~a;
    endtask

    // ==========================================================
    // Request length measured in core clocks
    always @(negedge core_clk) begin
        if (watch && transferRequestOut === ~actLow)
            runLen = runLen + 16'h0001;
        else if (runLen != 16'h0000) begin
            post(runLen);
            runLen = 16'h0000;
        end
    end
endmodule

/* verif/tb_dma_request_lock_swap_regs.sv */
module tb_dma_request_lock_swap_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_ctl_pkg::*;

    // Arbitrary revision value
    localparam logic [15:0] REV = 16'h0A5C;

    logic        core_clk, rst, bootLoadValid, xferStart;
    logic        protAccessReq, actLow, watch;
    logic [9:0]  bootLoadAddr;
    logic [15:0] bootLoadData, xferWords, hostAddr, hostDataIn;
    logic [15:0] hostDataOut, seenValue, tmp;
    logic        ceN, oeN, weN, hostDataOe, transferRequestOut;
    logic        protAccessGrant, stickyPartitionLock, byteSwapOn, bootMode;
    int          n_errors = 0;
    int          n_checks = 0;
    logic [15:0] expq[$];
    logic [15:0] w[4];
    logic [31:0] seed = 32'd47782;
    logic [15:0] sw[5] = '{16'h0001, 16'h0000, 16'h0100, 16'hFEFE, 16'h0101};
    logic        swOn[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    dma_request_lock_swap_regs #(.REVISION(REV)) u_dut (
        .core_clk(core_clk), .rst(rst), .hostAddr(hostAddr),
        .hostDataIn(hostDataIn), .ceN(ceN), .oeN(oeN), .weN(weN),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .bootLoadValid(bootLoadValid), .bootLoadAddr(bootLoadAddr),
        .bootLoadData(bootLoadData), .xferStart(xferStart),
        .xferWords(xferWords), .transferRequestOut(transferRequestOut),
        .protAccessReq(protAccessReq), .protAccessGrant(protAccessGrant),
        .stickyPartitionLock(stickyPartitionLock),
        .byteSwapOn(byteSwapOn), .bootMode(bootMode));

    host_bus_model u_host (
        .core_clk(core_clk), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
        .ceN(ceN), .oeN(oeN), .weN(weN), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .transferRequestOut(transferRequestOut),
        .actLow(actLow), .watch(watch), .seenValue(seenValue));

    // ==========================================================
    // Checking
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        n_checks++;
        if (got !== want) begin
            n_errors++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Unexpected results compare against unknown and so always fail
    always @(u_host.seen) begin
        if (expq.size() == 0)
            check(seenValue, 16'hxxxx);
        else
            check(seenValue, expq.pop_front());
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // ==========================================================
    // Helpers
    task automatic rreg(input logic [15:0] a, input logic [15:0] want);
        expq.push_back(want);
        u_host.rd(a, 1);
    endtask

    task automatic drain(input int lim);
        int k;
        k = 0;
        while (expq.size() != 0 && k < lim) begin
            @(posedge core_clk);
            k++;
        end
        if (expq.size() != 0) begin
            n_errors++;
            final_report();
        end
    endtask

    // Program control, start one transfer, expect a request length
    task automatic req(input logic [15:0] ctl, input logic [15:0] words,
                       input int len);
        u_host.wr(DMA_CTRL_OFS, ctl);
        repeat (2) @(posedge core_clk);
        actLow <= ctl[POL_BIT];
        watch  <= 1'b1;
        if (len > 0)
            expq.push_back(16'(len));
        @(posedge core_clk);
        xferStart <= 1'b1;
        xferWords <= words;
        @(posedge core_clk);
        xferStart <= 1'b0;
        xferWords <= ~words;
        drain(1100);
        // Idle time also catches requests that should never appear
        repeat (40) @(posedge core_clk);
        watch <= 1'b0;
        @(negedge core_clk);
        // Inactive level equals the polarity bit itself
        check(16'(transferRequestOut), {15'h0000, ctl[POL_BIT]});
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        final_report();
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst           = 1'b1;
        bootLoadValid = 1'b0;
        bootLoadAddr  = 10'h000;
        bootLoadData  = 16'h0000;
        xferStart     = 1'b0;
        xferWords     = 16'h0000;
        protAccessReq = 1'b0;
        actLow        = 1'b1;
        watch         = 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check(16'(transferRequestOut), 16'h0001);
        check(16'(bootMode), 16'h0001);
        for (int i = 0; i < 4; i++) begin
            tmp = 16'(rnd());
            w[i] = tmp;
            @(posedge core_clk);
            bootLoadValid <= 1'b1;
            bootLoadAddr  <= 10'(i);
            bootLoadData  <= tmp;
        end
        @(posedge core_clk);
        bootLoadValid <= 1'b0;
        foreach (w[i]) expq.push_back(w[i]);
        u_host.rd(16'h0000, 4);
        rreg(DMA_CTRL_OFS, 16'h0042);
        rreg(NEG_OFS, 16'h0004);
        rreg(LOCK_OFS, 16'h0000);
        rreg(ORDER_OFS, 16'h0000);
        rreg(REV_OFS, REV);
        rreg(REV_OFS | 16'h0001, 16'hFFFF);
        u_host.wr(NEG_OFS, 16'hFFFF);
        rreg(NEG_OFS, 16'h03FF);
        @(negedge core_clk);
        check(16'(bootMode), 16'h0000);
        expq.push_back(w[0]);
        expq.push_back(w[0]);
        u_host.rd(16'h0000, 2);
        u_host.wr(REV_OFS, ~REV);
        rreg(REV_OFS, REV);
        u_host.wr(DMA_CTRL_OFS | 16'h0001, 16'h0015);
        rreg(DMA_CTRL_OFS, 16'h0042);
        u_host.wr(DMA_CTRL_OFS, 16'hFFFF);
        rreg(DMA_CTRL_OFS, 16'h01F7);
        // Lock and protected access
        @(posedge core_clk);
        protAccessReq <= 1'b1;
        @(posedge core_clk);
        @(negedge core_clk);
        check(16'(protAccessGrant), 16'h0001);
        u_host.wr(LOCK_OFS, 16'hFFFF);
        rreg(LOCK_OFS, 16'h0001);
        @(negedge core_clk);
        check(16'(protAccessGrant), 16'h0000);
        u_host.wr(LOCK_OFS, 16'h0000);
        rreg(LOCK_OFS, 16'h0001);
        @(negedge core_clk);
        check(16'(stickyPartitionLock), 16'h0001);
        // Edge-mode requests, boundary and random widths
        req(16'h0015, 16'h0010, 1);
        req(16'h0035, 16'h0010, 3);
        req(16'h01F5, 16'h0010, 31);
        for (int i = 0; i < 3; i++) begin
            tmp = 16'(rnd());
            req({7'h00, tmp[4:0], 4'h5}, 16'h0010, int'(tmp[4:0]));
        end
        req(16'h0005, 16'h0010, 0);
        req(16'h0057, 16'h0010, 5);
        req(16'h0056, 16'h0010, 0);
        // Level mode: negation kept below transfer length
        u_host.wr(NEG_OFS, 16'h0003);
        req(16'h0041, 16'h000A, 7);
        u_host.wr(NEG_OFS, 16'h0000);
        req(16'h0041, 16'h0005, 5);
        // Byte order control
        foreach (sw[i]) begin
            u_host.wr(ORDER_OFS, sw[i]);
            @(negedge core_clk);
            check(16'(byteSwapOn), 16'(swOn[i]));
        end
        expq.push_back({w[0][7:0], w[0][15:8]});
        u_host.rd(16'h0000, 1);
        drain(10);
        final_report();
    end
endmodule
